/* File: pkg/spf_pkg.sv */
`default_nettype none
package spf_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEGLITCH_NS = 3000;
    localparam int DEGLITCH_CYCLES =
        (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [8:0] DEG_LAST = 9'(DEGLITCH_CYCLES - 1);
    localparam logic [1:0] CFG_SETTLE = 2'h3;
    localparam logic [2:0] FOLDBACK_FAULTS = 3'h7;

    // ------------------------------------------------------------
    // Register map and bus answers
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CTRL_FORCE_OFF = 0;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_UVLO = 1;
    localparam int IRQ_FOLD = 2;
    localparam int IRQ_RELEASE = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_OFF, ST_ON, ST_FAULT, ST_RETRY}
        spf_state_type;
    typedef enum logic [1:0] {VAR_SHUTOFF, VAR_FOLDBACK, VAR_REGULATE}
        spf_variant_type;

    typedef struct packed {
        logic enable;
        logic diagnostic_enable_input;
        logic fault_hold;
        logic sense_select_input;
        logic oc_cmp;
        logic abs_hot_cmp;
        logic rel_hot_cmp;
        logic hys_recovered_cmp;
        logic uv_fall_cmp;
        logic uv_rise_cmp;
        logic vout_up_cmp;
        logic [1:0] variant_cfg;
    } spf_pins_type;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } spf_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } spf_axi_rsp_type;

    typedef struct packed {
        logic [2:0] fault_cnt;
        spf_variant_type variant;
        spf_state_type fsm;
        logic limit_half;
        logic uv_lock;
        logic rel_flag;
        logic abs_flag;
        logic oc_trip;
        logic switch_on;
        logic sense_fault;
    } spf_status_type;

    typedef struct packed {
        spf_pins_type sync1;
        spf_pins_type sync2;
        spf_variant_type variant;
        logic [1:0] cfg_cnt;
        logic cfg_done;
        spf_state_type fsm;
        logic [15:0] retry_cnt;
        logic retry_done;
        logic [8:0] oc_cnt;
        logic oc_trip;
        logic abs_flag;
        logic rel_flag;
        logic uv_lock;
        logic [2:0] fault_cnt;
        logic clean_on;
        logic limit_half;
        logic switch_on;
        logic sense_fault;
        logic sense_en;
        logic sense_temp;
        logic force_off;
        logic [3:0] istat;
        logic [3:0] ien;
        logic irq;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        spf_axi_rsp_type rsp;
    } spf_regs_type;

    localparam spf_regs_type REGS_RESET = '0;
endpackage : spf_pkg
`default_nettype wire

/* File: design/spf_ctrl.sv */
// Function
// - Thermal or current trip forces switch off and enters fault state.
// - In fault state the sense output shows the fault level.
// - Leave fault only with hold low, retry expired, all faults clear.
// - Thermal fault on absolute or relative overtemperature.
// - Absolute fault clears on hysteresis; relative fault clears at retry.
// - Reaching current limit turns channel off once the deglitch window expires.
// - Overcurrent passes a 3 us deglitch filter before tripping.
// - Regulating variant flags fault while actively limiting current.
// - Regulating variant keeps conducting on overcurrent; thermal trip only.
// - Foldback variant halves limit after seven consecutive fault shutdowns.
// - Standby or clean on/off cycle restores full limit, resets count.
// - Other variants never reduce the current limit.
// - Undervoltage falling shuts output; rising level resumes operation.
// - After retry, fault indication holds until output voltage has risen.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`default_nettype none
module spf_ctrl
    import spf_pkg::*;
#(
    parameter logic [15:0] RETRY_CYCLES = 16'h03e8
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire spf_pins_type pins,
    input wire spf_axi_req_type axi_req,
    output spf_axi_rsp_type axi_rsp,
    output logic switch_on,
    output logic sense_fault,
    output logic sense_enable,
    output logic sense_temp,
    output logic limit_half,
    output logic irq
);

    // ------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------
    spf_regs_type s;
    spf_regs_type next_s;
    spf_pins_type p;
    logic trip;
    logic go;
    logic release_ok;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic reg_hit(input logic [7:0] a);
        return a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_IRQ_STAT ||
               a == ADDR_IRQ_CLR || a == ADDR_IRQ_EN;
    endfunction : reg_hit

    // Only synchronised copies are read by logic
    assign p = s.sync2;
    assign trip = s.abs_flag | s.rel_flag |
                  (s.oc_trip & (s.variant != VAR_REGULATE));
    assign go = s.cfg_done & p.enable & ~s.force_off & ~s.uv_lock;
    assign release_ok = ~p.fault_hold & s.retry_done & ~trip;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] ev;
        logic [3:0] clr;
        logic [31:0] wv;
        spf_status_type st;
        st = '0;
        ev = '0;
        clr = '0;
        wv = '0;
        next_s = s;
        next_s.sync1 = pins;
        next_s.sync2 = s.sync1;

        // Variant strap caught a few edges after reset release
        if (!s.cfg_done) begin
            next_s.cfg_cnt = s.cfg_cnt + 2'h1;
            if (s.cfg_cnt == CFG_SETTLE) begin
                next_s.cfg_done = 1'b1;
                case (p.variant_cfg)
                    2'h1: next_s.variant = VAR_FOLDBACK;
                    2'h2: next_s.variant = VAR_REGULATE;
                    default: next_s.variant = VAR_SHUTOFF;
                endcase
            end
        end

        // Undervoltage lockout with separate fall and rise levels
        if (p.uv_fall_cmp) begin
            next_s.uv_lock = 1'b1;
        end else if (p.uv_rise_cmp) begin
            next_s.uv_lock = 1'b0;
        end
        if (next_s.uv_lock && !s.uv_lock) begin
            ev[IRQ_UVLO] = 1'b1;
        end

        // Overcurrent deglitch; a glitch shorter than the window is lost
        if (!p.oc_cmp) begin
            next_s.oc_cnt = '0;
            next_s.oc_trip = 1'b0;
        end else if (s.oc_cnt != DEG_LAST) begin
            next_s.oc_cnt = s.oc_cnt + 9'h001;
        end else begin
            next_s.oc_trip = 1'b1;
        end

        // Thermal flags, a new trip wins over its clear
        next_s.abs_flag = p.abs_hot_cmp |
                          (s.abs_flag & ~p.hys_recovered_cmp);
        next_s.rel_flag = p.rel_hot_cmp |
                          (s.rel_flag & ~s.retry_done);

        // Retry interval runs only inside the fault state
        if (s.fsm == ST_FAULT && !s.retry_done) begin
            if (s.retry_cnt == RETRY_CYCLES - 16'h0001) begin
                next_s.retry_done = 1'b1;
            end else begin
                next_s.retry_cnt = s.retry_cnt + 16'h0001;
            end
        end

        // Switch sequencing
        case (s.fsm)
            ST_OFF: begin
                if (go && !trip) begin
                    next_s.fsm = ST_ON;
                    next_s.clean_on = 1'b1;
                end
            end
            ST_ON, ST_RETRY: begin
                if (trip) begin
                    next_s.fsm = ST_FAULT;
                    next_s.retry_cnt = '0;
                    next_s.retry_done = 1'b0;
                    next_s.clean_on = 1'b0;
                    ev[IRQ_FAULT] = 1'b1;
                    if (s.fault_cnt != FOLDBACK_FAULTS) begin
                        next_s.fault_cnt = s.fault_cnt + 3'h1;
                    end
                end else if (!go) begin
                    next_s.fsm = ST_OFF;
                    if (s.fsm == ST_ON && s.clean_on) begin
                        next_s.fault_cnt = '0;
                    end
                end else if (s.fsm == ST_RETRY && p.vout_up_cmp) begin
                    next_s.fsm = ST_ON;
                end
            end
            ST_FAULT: begin
                if (release_ok) begin
                    next_s.fsm = go ? ST_RETRY : ST_OFF;
                    ev[IRQ_RELEASE] = 1'b1;
                end
            end
            default: next_s.fsm = ST_OFF;
        endcase

        // Standby: neither enable nor diagnostics requested
        if (!p.enable && !p.diagnostic_enable_input) begin
            next_s.fault_cnt = '0;
        end

        // Halved limit only exists in the foldback variant
        next_s.limit_half = (s.variant == VAR_FOLDBACK) &&
                            (next_s.fault_cnt == FOLDBACK_FAULTS);
        if (next_s.limit_half && !s.limit_half) begin
            ev[IRQ_FOLD] = 1'b1;
        end

        // Pin-side outputs
        next_s.switch_on = (next_s.fsm == ST_ON || next_s.fsm == ST_RETRY) &&
                           !next_s.uv_lock;
        next_s.sense_fault = next_s.fsm == ST_FAULT ||
                             next_s.fsm == ST_RETRY ||
                             (s.variant == VAR_REGULATE && p.oc_cmp &&
                              next_s.fsm == ST_ON);
        next_s.sense_en = p.diagnostic_enable_input;
        next_s.sense_temp = p.sense_select_input;

        // Write channel: address and data taken in either order
        if (s.rsp.bvalid && axi_req.bready) begin
            next_s.rsp.bvalid = 1'b0;
        end
        if (axi_req.awvalid && s.rsp.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s.rsp.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = axi_req.wdata;
            next_s.wstrb = axi_req.wstrb;
        end
        if (next_s.aw_got && next_s.w_got && !s.rsp.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.rsp.bvalid = 1'b1;
            next_s.rsp.bresp = reg_hit(next_s.awaddr) ? RESP_OKAY
                                                      : RESP_SLVERR;
            case (next_s.awaddr)
                ADDR_CTRL: begin
                    wv = merge({31'h0, s.force_off}, next_s.wdata,
                               next_s.wstrb);
                    next_s.force_off = wv[CTRL_FORCE_OFF];
                end
                ADDR_IRQ_EN: begin
                    wv = merge({28'h0, s.ien}, next_s.wdata, next_s.wstrb);
                    next_s.ien = wv[3:0];
                end
                ADDR_IRQ_CLR: begin
                    wv = merge(32'h0, next_s.wdata, next_s.wstrb);
                    clr = wv[3:0];
                end
                default: wv = '0;
            endcase
        end
        next_s.rsp.awready = !next_s.aw_got;
        next_s.rsp.wready = !next_s.w_got;

        // Read channel, one outstanding read
        if (s.rsp.rvalid && axi_req.rready) begin
            next_s.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && s.rsp.arready) begin
            st = '{s.fault_cnt, s.variant, s.fsm, s.limit_half, s.uv_lock,
                   s.rel_flag, s.abs_flag, s.oc_trip, s.switch_on,
                   s.sense_fault};
            next_s.rsp.rvalid = 1'b1;
            next_s.rsp.rresp = reg_hit(axi_req.araddr) ? RESP_OKAY
                                                       : RESP_SLVERR;
            case (axi_req.araddr)
                ADDR_CTRL: next_s.rsp.rdata = {31'h0, s.force_off};
                ADDR_STATUS: next_s.rsp.rdata = 32'(st);
                ADDR_IRQ_STAT: next_s.rsp.rdata = {28'h0, s.istat};
                ADDR_IRQ_EN: next_s.rsp.rdata = {28'h0, s.ien};
                default: next_s.rsp.rdata = '0;
            endcase
        end
        next_s.rsp.arready = !next_s.rsp.rvalid;

        // Sticky events: a new event beats a clear in the same cycle
        next_s.istat = (s.istat & ~clr) | ev;
        next_s.irq = |(next_s.istat & next_s.ien);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= REGS_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Every output straight from the state register
    assign axi_rsp = s.rsp;
    assign switch_on = s.switch_on;
    assign sense_fault = s.sense_fault;
    assign sense_enable = s.sense_en;
    assign sense_temp = s.sense_temp;
    assign limit_half = s.limit_half;
    assign irq = s.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_trip_on;
        s.fsm == ST_ON && trip && s.cfg_done;
    endsequence
    sequence s_leave_fault;
        s.fsm == ST_FAULT ##1 s.fsm != ST_FAULT;
    endsequence

    property p_trip_off;
        s_trip_on |=> s.fsm == ST_FAULT && !switch_on;
    endproperty
    a_trip_off: assert property (p_trip_off)
        else $error("trip did not force fault with switch off");

    property p_fault_sense;
        s.fsm == ST_FAULT |-> sense_fault && !switch_on;
    endproperty
    a_fault_sense: assert property (p_fault_sense)
        else $error("fault state without fault indication");

    property p_release;
        s_leave_fault |-> $past(release_ok);
    endproperty
    a_release: assert property (p_release)
        else $error("fault left before release conditions held");

    property p_abs_flag;
        p.abs_hot_cmp |=> s.abs_flag;
    endproperty
    a_abs_flag: assert property (p_abs_flag)
        else $error("absolute overtemperature not flagged");

    property p_rel_clear;
        s.rel_flag && !p.rel_hot_cmp && s.retry_done |=> !s.rel_flag;
    endproperty
    a_rel_clear: assert property (p_rel_clear)
        else $error("relative thermal fault not cleared at retry");

    property p_oc_off;
        s_trip_on ##0 s.oc_trip ##0 s.variant != VAR_REGULATE
            |=> !switch_on;
    endproperty
    a_oc_off: assert property (p_oc_off)
        else $error("overcurrent did not turn channel off");

    property p_deglitch;
        $rose(s.oc_trip) |-> $past(s.oc_cnt) == DEG_LAST;
    endproperty
    a_deglitch: assert property (p_deglitch)
        else $error("overcurrent tripped before deglitch window");

    property p_reg_limit;
        s.fsm == ST_ON && s.variant == VAR_REGULATE && p.oc_cmp &&
            go && !s.abs_flag && !s.rel_flag && !p.uv_fall_cmp
            |=> s.fsm == ST_ON && sense_fault && switch_on;
    endproperty
    a_reg_limit: assert property (p_reg_limit)
        else $error("regulating variant mishandled current limiting");

    property p_fold;
        limit_half |-> s.variant == VAR_FOLDBACK &&
                       s.fault_cnt == FOLDBACK_FAULTS;
    endproperty
    a_fold: assert property (p_fold)
        else $error("limit halved without seven faults in foldback");

    property p_standby;
        !p.enable && !p.diagnostic_enable_input |=> s.fault_cnt == 3'h0;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby did not restart fault count");

    property p_uvlo;
        p.uv_fall_cmp |=> s.uv_lock && !switch_on;
    endproperty
    a_uvlo: assert property (p_uvlo)
        else $error("undervoltage did not shut output");

    property p_retry_hold;
        s.fsm == ST_RETRY && !p.vout_up_cmp && !trip && go
            |=> s.fsm == ST_RETRY && sense_fault;
    endproperty
    a_retry_hold: assert property (p_retry_hold)
        else $error("fault indication dropped before output rose");

    property p_variant;
        s.cfg_done |=> $stable(s.variant);
    endproperty
    a_variant: assert property (p_variant)
        else $error("variant changed after configuration");

    property p_retry_start;
        $rose(s.fsm == ST_FAULT) |-> s.retry_cnt == 16'h0000 &&
                                     !s.retry_done;
    endproperty
    a_retry_start: assert property (p_retry_start)
        else $error("retry counter not restarted on fault entry");

endmodule : spf_ctrl
`default_nettype wire

/* File: dv/spf_plant_model.sv */
`default_nettype none
module spf_plant_model
    import spf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic switch_on,
    input wire logic short_cmd,
    output logic oc_cmp,
    output logic vout_up_cmp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] rise_cnt;
    // A short only draws current while the switch conducts
    assign oc_cmp = switch_on & short_cmd;
    // Output climbs slowly; a shorted output never comes up
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rise_cnt <= 4'h0;
        end else if (!switch_on || short_cmd) begin
            rise_cnt <= 4'h0;
        end else if (rise_cnt != 4'hf) begin
            rise_cnt <= rise_cnt + 4'h1;
        end
    end
    assign vout_up_cmp = (rise_cnt > 4'h8);
endmodule : spf_plant_model
`default_nettype wire

/* File: dv/spf_ctrl_test.sv */
`default_nettype none
module spf_ctrl_test
    import spf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic short_cmd = 1'b0;
    logic oc, vup, switch_on, sense_fault, limit_half, irq;
    logic sense_enable, sense_temp;
    spf_pins_type drv = '0;
    spf_pins_type pins;
    spf_axi_req_type req = '0;
    spf_axi_rsp_type rsp;
    logic [31:0] seed = 32'h51;
    logic [33:0] note;
    logic [33:0] note_q[$];
    int errors = 0;
    int n_checks = 0;
    event obs_ev;
    wire logic [5:0] obs = {sense_temp, sense_enable, irq, limit_half,
        sense_fault, switch_on};

    always #5 ref_clk = ~ref_clk;
    // Plant owns the current and output-voltage comparators
    always_comb begin
        pins = drv;
        pins.oc_cmp = oc;
        pins.vout_up_cmp = vup;
    end

    spf_ctrl #(.RETRY_CYCLES(16'h0010)) i_dut (.ref_clk(ref_clk),
        .rst_b(rst_b), .pins(pins), .axi_req(req), .axi_rsp(rsp),
        .switch_on(switch_on), .sense_fault(sense_fault),
        .sense_enable(sense_enable), .sense_temp(sense_temp),
        .limit_half(limit_half),
        .irq(irq));
    spf_plant_model i_plant (.ref_clk(ref_clk), .rst_b(rst_b),
        .switch_on(switch_on), .short_cmd(short_cmd), .oc_cmp(oc),
        .vout_up_cmp(vup));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic chk(input string nm, input logic [33:0] seen,
                       input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // Bus answers are matched to notes in issue order
    always @(posedge ref_clk) begin
        if (rsp.bvalid && req.bready) begin
            chk("bresp", {rsp.bresp, 32'h0}, note_q.pop_front());
        end
        if (rsp.rvalid && req.rready) begin
            chk("rdata", {rsp.rresp, rsp.rdata}, note_q.pop_front());
        end
    end
    // Output notes carry a mask and the expected levels
    always begin
        @(obs_ev);
        note = note_q.pop_front();
        chk("outputs", {28'h0, obs & note[11:6]}, {28'h0, note[5:0]});
    end

    task automatic expect_obs(input logic [3:0] m, input logic [3:0] v);
        note_q.push_back({22'h0, 2'h0, m, 2'h0, v});
        -> obs_ev;
        @(posedge ref_clk);
    endtask : expect_obs

    // Sense path outputs: bit 1 temperature select, bit 0 enable
    task automatic expect_sense(input logic [1:0] m, input logic [1:0] v);
        note_q.push_back({22'h0, m, 4'h0, v, 4'h0});
        -> obs_ev;
        @(posedge ref_clk);
    endtask : expect_sense

    // Bounded wait on one output bit, then note its level
    task automatic wait_bit(input int b, input logic v, input int lim);
        int k;
        k = 0;
        while (obs[b] !== v && k < lim) begin
            @(posedge ref_clk);
            k++;
        end
        expect_obs(4'h1 << b, {3'h0, v} << b);
    endtask : wait_bit

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        @(posedge ref_clk);
        note_q.push_back({r, 32'h0});
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge ref_clk);
        note_q.push_back(e);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        req.rready <= 1'b0;
    endtask : axi_rd

    // Supply is good before reset ends, so enable may rise later
    task automatic do_reset(input logic [1:0] cfg);
        spf_pins_type p;
        p = '0;
        p.variant_cfg = cfg;
        p.uv_rise_cmp = 1'b1;
        p.diagnostic_enable_input = 1'b1;
        rst_b <= 1'b0;
        short_cmd <= 1'b0;
        drv <= p;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask : do_reset

    // Auto-retry into a standing short; limit halves at the 7th trip
    task automatic fault_run(input int n, input int fold_at);
        for (int i = 0; i < n; i++) begin
            wait_bit(0, 1'b0, 1000);
            repeat (6) @(posedge ref_clk);
            expect_obs(4'h4, (i >= fold_at) ? 4'h4 : 4'h0);
            wait_bit(0, 1'b1, 200);
        end
    endtask : fault_run

    initial begin
        do_reset(2'h0);
        axi_rd(ADDR_CTRL, {RESP_OKAY, 32'h0});
        axi_rd(ADDR_IRQ_EN, {RESP_OKAY, 32'h0});
        axi_rd(8'h14, {RESP_SLVERR, 32'h0});
        axi_wr(8'h20, 32'h1, RESP_SLVERR);
        seed = xs(seed);
        axi_wr(ADDR_IRQ_EN, seed, RESP_OKAY);
        axi_rd(ADDR_IRQ_EN, {RESP_OKAY, 28'h0, seed[3:0]});
        axi_wr(ADDR_IRQ_EN, 32'hf, RESP_OKAY);
        axi_wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        drv.enable <= 1'b1;
        drv.sense_select_input <= 1'b1;
        repeat (20) @(posedge ref_clk);
        expect_obs(4'h1, 4'h0);
        expect_sense(2'h3, 2'h3);
        axi_wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        wait_bit(0, 1'b1, 20);
        expect_obs(4'hf, 4'h1);
        // Short with hold high: filtered trip, then latched off
        drv.fault_hold <= 1'b1;
        short_cmd <= 1'b1;
        repeat (290) @(posedge ref_clk);
        expect_obs(4'h1, 4'h1);
        wait_bit(0, 1'b0, 20);
        expect_obs(4'hf, 4'ha);
        repeat (60) @(posedge ref_clk);
        expect_obs(4'h3, 4'h2);
        axi_rd(ADDR_IRQ_STAT, {RESP_OKAY, 32'h1});
        axi_rd(ADDR_STATUS, {RESP_OKAY, 32'h901});
        axi_wr(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
        repeat (3) @(posedge ref_clk);
        expect_obs(4'h8, 4'h0);
        axi_wr(ADDR_IRQ_CLR, 32'h1, RESP_OKAY);
        axi_rd(ADDR_IRQ_STAT, {RESP_OKAY, 32'h0});
        axi_wr(ADDR_IRQ_EN, 32'hf, RESP_OKAY);
        short_cmd <= 1'b0;
        @(posedge ref_clk);
        drv.fault_hold <= 1'b0;
        wait_bit(0, 1'b1, 100);
        expect_obs(4'h2, 4'h2);
        wait_bit(1, 1'b0, 60);
        axi_rd(ADDR_IRQ_STAT, {RESP_OKAY, 32'h8});
        axi_wr(ADDR_IRQ_CLR, 32'hf, RESP_OKAY);
        repeat (3) @(posedge ref_clk);
        expect_obs(4'h8, 4'h0);
        // Absolute overtemperature waits for hysteresis
        drv.abs_hot_cmp <= 1'b1;
        wait_bit(0, 1'b0, 20);
        drv.abs_hot_cmp <= 1'b0;
        repeat (60) @(posedge ref_clk);
        expect_obs(4'h3, 4'h2);
        drv.hys_recovered_cmp <= 1'b1;
        wait_bit(0, 1'b1, 100);
        wait_bit(1, 1'b0, 60);
        drv.hys_recovered_cmp <= 1'b0;
        @(posedge ref_clk);
        drv.rel_hot_cmp <= 1'b1;
        wait_bit(0, 1'b0, 20);
        drv.rel_hot_cmp <= 1'b0;
        wait_bit(0, 1'b1, 100);
        drv.uv_fall_cmp <= 1'b1;
        wait_bit(0, 1'b0, 20);
        drv.uv_fall_cmp <= 1'b0;
        wait_bit(0, 1'b1, 40);
        axi_rd(ADDR_IRQ_STAT, {RESP_OKAY, 32'hb});
        short_cmd <= 1'b1;
        fault_run(8, 99);
        do_reset(2'h1);
        drv.enable <= 1'b1;
        wait_bit(0, 1'b1, 20);
        short_cmd <= 1'b1;
        fault_run(7, 6);
        short_cmd <= 1'b0;
        wait_bit(1, 1'b0, 200);
        axi_rd(ADDR_IRQ_STAT, {RESP_OKAY, 32'hd});
        drv.enable <= 1'b0;
        repeat (10) @(posedge ref_clk);
        expect_obs(4'h4, 4'h4);
        drv.enable <= 1'b1;
        wait_bit(0, 1'b1, 20);
        drv.enable <= 1'b0;
        wait_bit(2, 1'b0, 20);
        do_reset(2'h2);
        drv.enable <= 1'b1;
        wait_bit(0, 1'b1, 20);
        short_cmd <= 1'b1;
        wait_bit(1, 1'b1, 20);
        repeat (400) @(posedge ref_clk);
        expect_obs(4'h3, 4'h3);
        drv.rel_hot_cmp <= 1'b1;
        wait_bit(0, 1'b0, 20);
        drv.diagnostic_enable_input <= 1'b0;
        repeat (6) @(posedge ref_clk);
        expect_sense(2'h3, 2'h0);
        test_done();
    end

    // The whole run needs about 6000 cycles
    initial begin
        repeat (30000) @(posedge ref_clk);
        errors++;
        test_done();
    end
endmodule : spf_ctrl_test
`default_nettype wire
